// ==== rtl/rci_pulse_div.sv ====
// Tick divider: one output pulse for every DIV input ticks.
// Assumes tick_i is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/1ns
module rci_pulse_div #(
  parameter int DIV = 10
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  output logic      pulse_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        pulse;
  } rci_div_type;

  rci_div_type s_r;
  rci_div_type s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    if (tick_i) begin
      if (s_r.cnt == 16'(DIV - 1)) begin
        s_nxt.cnt   = 16'h0;
        s_nxt.pulse = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pulse_o = s_r.pulse;

  property p_div_src;
    @(posedge clk_i) disable iff (rst_i)
      pulse_o |-> $past(tick_i) && $past(s_r.cnt) == 16'(DIV - 1);
  endproperty
  a_div_src: assert property (p_div_src) else $error("Divider pulse without final tick");

  property p_div_rate;
    @(posedge clk_i) disable iff (rst_i)
      tick_i && s_r.cnt != 16'(DIV - 1) |=> !pulse_o;
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("Divider pulse too early");
endmodule // rci_pulse_div

// ==== rtl/rci_run_ctrl.sv ====
// Remote run control: two remote inputs, one open collector output, registers.
// Assumes pins already thresholded to logic levels; low means active.
//
// Notes on behaviour
// - Level mode on input one runs pump while low, stops while high.
// - Pulse mode without timer: a low pulse starts, the next one stops.
// - Level mode with timer starts on low, stops on return high.
// - Pulse mode with timer: low pulse starts, run time expiry stops.
// - With input one enabled only it may start the pump.
// - With analog enabled a start needs a valid analog signal.
// - After any stop, restarts are blocked for 0.2 seconds.
// - Comes up halted; local start moves it to paused.
// - Off setting makes a remote input ignored entirely.
// - Reset mode low level aborts metering, clears errors, goes paused.
// - Reset and combined actions release the halt into paused; a prime action releases it into priming.
// - Prime mode low aborts, clears errors, primes while held low.
// - Combined falling edge aborts and clears; held over 1 s primes.
// - Input two level and pulse modes match those of input one, except that level mode with timer ignores release.
// - Foot switch level mode runs while held, stops on release.
// - Foot switch pulse mode toggles run and stop on each press.
// - With timer, a foot switch start runs one whole timed cycle.
// - Output selectable to alarm, motor running or volume end level.
// - Motor pulse mode gives ten pulses per motor revolution.
// - Volume pulse mode gives one pulse per 100 microlitres.
// - Local stop sets the halt; only a manual start or an input two reset, prime or combined action leaves it.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
module rci_run_ctrl
  import rci_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int MOT_DIV   = MOT_DIV_DEF,
  parameter int VOL_DIV   = VOL_DIV_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        din1_i,
  input  wire logic        din2_i,
  input  wire logic        analog_valid_i,
  input  wire logic        local_start_i,
  input  wire logic        local_stop_i,
  input  wire logic        pump_err_i,
  input  wire logic        mot_tick_i,
  input  wire logic        vol_tick_i,
  input  wire logic        dout_i,
  output logic             dout_o,
  output logic             dout_oe_n_o,
  output logic             run_o,
  output logic             prime_o,
  output logic             err_clr_o
);
  typedef struct packed {
    logic          in1_m;
    logic          in1_s;
    logic          in1_d;
    logic          in2_m;
    logic          in2_s;
    logic          in2_d;
    rci_state_type st;
    logic [31:0]   ms_cnt;
    logic [15:0]   lock_cnt;
    logic [15:0]   hold_cnt;
    logic [15:0]   tim_cnt;
    logic [15:0]   run_time;
    rci_in1_type   in1_mode;
    rci_in2_type   in2_mode;
    rci_out_type   out_sel;
    logic          timer_en;
    logic          analog_en;
    logic          vol_end;
    logic          err_clr;
    logic          dout_act;
    logic          ack;
    logic [31:0]   rdat;
  } rci_regs_type;

  rci_regs_type s_r;
  rci_regs_type s_nxt;

  logic ms_tick;
  logic low1;
  logic low2;
  logic fall1;
  logic fall2;
  logic busy;
  logic timer_on;
  logic can_start;
  logic start_req;
  logic stop_req;
  logic abort2;
  logic prime_on;
  logic expire;
  logic bus_req;
  logic mot_pulse;
  logic vol_pulse;

  rci_pulse_div #(
    .DIV (MOT_DIV)
  ) u_mot_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (mot_tick_i),
    .pulse_o (mot_pulse)
  );

  rci_pulse_div #(
    .DIV (VOL_DIV)
  ) u_vol_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (vol_tick_i),
    .pulse_o (vol_pulse)
  );

  always_comb begin
    s_nxt     = s_r;
    ms_tick   = 1'b0;
    start_req = 1'b0;
    stop_req  = 1'b0;
    abort2    = 1'b0;
    prime_on  = 1'b0;
    expire    = 1'b0;
    s_nxt.in1_m = din1_i;
    s_nxt.in1_s = s_r.in1_m;
    s_nxt.in1_d = s_r.in1_s;
    s_nxt.in2_m = din2_i;
    s_nxt.in2_s = s_r.in2_m;
    s_nxt.in2_d = s_r.in2_s;
    low1  = !s_r.in1_s;
    low2  = !s_r.in2_s;
    fall1 = s_r.in1_d && !s_r.in1_s;
    fall2 = s_r.in2_d && !s_r.in2_s;
    if (s_r.ms_cnt == 32'(MS_CYCLES - 1)) begin
      s_nxt.ms_cnt = 32'h0;
      ms_tick      = 1'b1;
    end else begin
      s_nxt.ms_cnt = s_r.ms_cnt + 32'h1;
    end
    busy = s_r.lock_cnt != 16'h0;
    if (busy && ms_tick) begin
      s_nxt.lock_cnt = s_r.lock_cnt - 16'h1;
    end
    can_start = !busy && (!s_r.analog_en || analog_valid_i);
    timer_on  = s_r.timer_en && !s_r.analog_en;
    if (s_r.in2_mode == IN2_COMB && low2 && !fall2) begin
      if (ms_tick && s_r.hold_cnt != HOLD_TICKS) begin
        s_nxt.hold_cnt = s_r.hold_cnt + 16'h1;
      end
    end else begin
      s_nxt.hold_cnt = 16'h0;
    end
    if (s_r.st == ST_RUN && timer_on && ms_tick) begin
      s_nxt.tim_cnt = s_r.tim_cnt + 16'h1;
      expire        = s_r.tim_cnt + 16'h1 >= s_r.run_time;
    end
    case (s_r.in1_mode)
      IN1_LEVEL: begin
        start_req = low1;
        stop_req  = !low1;
      end
      IN1_PULSE: begin
        start_req = fall1;
        stop_req  = fall1 && !timer_on;
      end
      default: begin
        case (s_r.in2_mode)
          IN2_LEVEL: begin
            start_req = low2;
            stop_req  = !low2 && !timer_on;
          end
          IN2_PULSE: begin
            start_req = fall2;
            stop_req  = fall2 && !timer_on;
          end
          default: begin
            start_req = local_start_i;
          end
        endcase
      end
    endcase
    case (s_r.in2_mode)
      IN2_RESET: begin
        abort2 = low2;
      end
      IN2_PRIME: begin
        abort2   = low2;
        prime_on = low2;
      end
      IN2_COMB: begin
        abort2   = low2;
        prime_on = low2 && s_r.hold_cnt == HOLD_TICKS;
      end
      default: begin
        abort2 = 1'b0;
      end
    endcase
    s_nxt.err_clr = fall2 && (s_r.in2_mode == IN2_RESET || s_r.in2_mode == IN2_PRIME ||
                              s_r.in2_mode == IN2_COMB);
    if (local_stop_i) begin
      s_nxt.st = ST_HALT;
      if (s_r.st == ST_RUN || s_r.st == ST_PRIME) begin
        s_nxt.lock_cnt = LOCK_TICKS;
      end
    end else if (prime_on) begin
      s_nxt.st = ST_PRIME;
    end else if (abort2) begin
      s_nxt.st = ST_PAUSE;
      if (s_r.st == ST_RUN || s_r.st == ST_PRIME) begin
        s_nxt.lock_cnt = LOCK_TICKS;
      end
    end else begin
      case (s_r.st)
        ST_HALT: begin
          if (local_start_i) begin
            s_nxt.st = ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          if (start_req && can_start) begin
            s_nxt.st      = ST_RUN;
            s_nxt.tim_cnt = 16'h0;
            s_nxt.vol_end = 1'b0;
          end
        end
        ST_RUN: begin
          if (stop_req || expire) begin
            s_nxt.st       = ST_PAUSE;
            s_nxt.lock_cnt = LOCK_TICKS;
            s_nxt.vol_end  = expire;
          end
        end
        ST_PRIME: begin
          s_nxt.st       = ST_PAUSE;
          s_nxt.lock_cnt = LOCK_TICKS;
        end
        default: begin
          s_nxt.st = ST_HALT;
        end
      endcase
    end
    case (s_r.out_sel)
      OUT_ALARM: s_nxt.dout_act = pump_err_i;
      OUT_MOTOR: s_nxt.dout_act = s_r.st == ST_RUN || s_r.st == ST_PRIME;
      OUT_VEND:  s_nxt.dout_act = s_r.vol_end;
      OUT_MPUL:  s_nxt.dout_act = mot_pulse;
      OUT_VPUL:  s_nxt.dout_act = vol_pulse;
      default:   s_nxt.dout_act = 1'b0;
    endcase
    // Wishbone slave, one wait cycle
    bus_req    = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack  = bus_req;
    s_nxt.rdat = 32'h0;
    if (bus_req) begin
      case (wb_adr_i)
        ADDR_CTRL: begin
          s_nxt.rdat[CTRL_IN1_LSB +: 2]  = s_r.in1_mode;
          s_nxt.rdat[CTRL_IN2_LSB +: 3]  = s_r.in2_mode;
          s_nxt.rdat[CTRL_OUT_LSB +: 3]  = s_r.out_sel;
          s_nxt.rdat[CTRL_TIMER_BIT]     = s_r.timer_en;
          s_nxt.rdat[CTRL_ANLG_BIT]      = s_r.analog_en;
          if (wb_we_i && wb_sel_i[0]) begin
            s_nxt.in1_mode = rci_in1_type'(wb_dat_i[CTRL_IN1_LSB +: 2]);
            s_nxt.in2_mode = rci_in2_type'(wb_dat_i[CTRL_IN2_LSB +: 3]);
          end
          if (wb_we_i && wb_sel_i[1]) begin
            s_nxt.out_sel   = rci_out_type'(wb_dat_i[CTRL_OUT_LSB +: 3]);
            s_nxt.timer_en  = wb_dat_i[CTRL_TIMER_BIT];
            s_nxt.analog_en = wb_dat_i[CTRL_ANLG_BIT];
          end
        end
        ADDR_RUNTIME: begin
          s_nxt.rdat[15:0] = s_r.run_time;
          if (wb_we_i && wb_sel_i[0]) begin
            s_nxt.run_time[7:0] = wb_dat_i[7:0];
          end
          if (wb_we_i && wb_sel_i[1]) begin
            s_nxt.run_time[15:8] = wb_dat_i[15:8];
          end
        end
        ADDR_STATUS: begin
          s_nxt.rdat[STAT_ST_LSB +: 4] = s_r.st;
          s_nxt.rdat[STAT_VEND_BIT]    = s_r.vol_end;
          s_nxt.rdat[STAT_LOCK_BIT]    = busy;
          s_nxt.rdat[STAT_ERR_BIT]     = pump_err_i;
          s_nxt.rdat[STAT_PIN_BIT]     = dout_i;
        end
        default: begin
          s_nxt.rdat = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.in1_m    <= 1'b1;
      s_r.in1_s    <= 1'b1;
      s_r.in1_d    <= 1'b1;
      s_r.in2_m    <= 1'b1;
      s_r.in2_s    <= 1'b1;
      s_r.in2_d    <= 1'b1;
      s_r.st       <= ST_HALT;
      s_r.run_time <= RUNTIME_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o    = s_r.rdat;
  assign wb_ack_o    = s_r.ack;
  assign dout_o      = 1'b0;
  assign dout_oe_n_o = !s_r.dout_act;
  assign run_o       = s_r.st == ST_RUN;
  assign prime_o     = s_r.st == ST_PRIME;
  assign err_clr_o   = s_r.err_clr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_stop;
    s_r.st == ST_RUN ##1 s_r.st == ST_PAUSE;
  endsequence
  sequence s_comb_fall;
    s_r.in2_mode == IN2_COMB && s_r.in2_d && !s_r.in2_s;
  endsequence

  property p_boot_halt;
    $past(rst_i) |-> s_r.st == ST_HALT;
  endproperty
  a_boot_halt: assert property (@(posedge clk_i) p_boot_halt) else $error("Not halted after reset");

  property p_stop_halt;
    local_stop_i |=> s_r.st == ST_HALT ##1 ($past(local_start_i) || $past(abort2) || $past(prime_on)
                                            || s_r.st == ST_HALT);
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("Halt left without manual action");

  property p_lockout;
    s_run_stop |-> s_r.lock_cnt == LOCK_TICKS ##1 s_r.st != ST_RUN [*8];
  endproperty
  a_lockout: assert property (p_lockout) else $error("Restart inside lockout");

  property p_analog;
    s_r.analog_en && !analog_valid_i && s_r.st == ST_PAUSE |=> s_r.st != ST_RUN;
  endproperty
  a_analog: assert property (p_analog) else $error("Start without valid analog signal");

  property p_in1_idle;
    s_r.in1_mode == IN1_LEVEL && s_r.in1_s && s_r.st == ST_PAUSE |=> s_r.st != ST_RUN;
  endproperty
  a_in1_idle: assert property (p_in1_idle) else $error("Run while input one high");

  property p_off;
    s_r.in1_mode == IN1_OFF && s_r.in2_mode == IN2_OFF && s_r.st == ST_PAUSE && !local_start_i
      && !local_stop_i |=> s_r.st == ST_PAUSE;
  endproperty
  a_off: assert property (p_off) else $error("Disabled input changed state");

  property p_prime;
    s_r.in2_mode == IN2_PRIME && low2 && !local_stop_i |=> s_r.st == ST_PRIME;
  endproperty
  a_prime: assert property (p_prime) else $error("No priming while input low");

  property p_comb;
    s_comb_fall and !local_stop_i |=> err_clr_o && s_r.st == ST_PAUSE;
  endproperty
  a_comb: assert property (p_comb) else $error("Combined edge did not clear");

  property p_reset;
    s_r.in2_mode == IN2_RESET && low2 && !local_stop_i |=> s_r.st == ST_PAUSE;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset mode not paused");

  property p_expire;
    expire && s_r.st == ST_RUN && !local_stop_i && !abort2 && !prime_on |=> s_r.st == ST_PAUSE && s_r.vol_end;
  endproperty
  a_expire: assert property (p_expire) else $error("Timer expiry did not stop");

  property p_alarm;
    s_r.out_sel == OUT_ALARM && $stable(s_r.out_sel) |-> dout_oe_n_o == !$past(pump_err_i);
  endproperty
  a_alarm: assert property (p_alarm) else $error("Alarm output wrong");
endmodule // rci_run_ctrl

// ==== shared/rci_pkg.sv ====
// Shared constants and types of the remote input run control.
// Assumes one 250 MHz clock and a Wishbone classic register port.
package rci_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS     = 1000000;
  localparam int MS_CYCLES_DEF = NS_PER_MS / CLK_PERIOD_NS;
  localparam int LOCKOUT_MS    = 200;
  localparam int HOLD_MS       = 1000;
  localparam int MIN_PULSE_MS  = 100;
  localparam logic [15:0] LOCK_TICKS = 16'(LOCKOUT_MS + 1);
  localparam logic [15:0] HOLD_TICKS = 16'(HOLD_MS + 1);

  // Output pulse dividers
  localparam int MOT_DIV_DEF = 10;
  localparam int VOL_DIV_DEF = 100;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_RUNTIME = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;

  // Control fields
  localparam int CTRL_IN1_LSB   = 0;
  localparam int CTRL_IN2_LSB   = 4;
  localparam int CTRL_OUT_LSB   = 8;
  localparam int CTRL_TIMER_BIT = 12;
  localparam int CTRL_ANLG_BIT  = 13;

  // Status fields
  localparam int STAT_ST_LSB   = 0;
  localparam int STAT_VEND_BIT = 4;
  localparam int STAT_LOCK_BIT = 5;
  localparam int STAT_ERR_BIT  = 6;
  localparam int STAT_PIN_BIT  = 7;

  // Reset values
  localparam logic [15:0] RUNTIME_RST = 16'h03e8;

  typedef enum logic [1:0] {
    IN1_OFF   = 2'h0,
    IN1_LEVEL = 2'h1,
    IN1_PULSE = 2'h2
  } rci_in1_type;

  typedef enum logic [2:0] {
    IN2_OFF   = 3'h0,
    IN2_RESET = 3'h1,
    IN2_PRIME = 3'h2,
    IN2_COMB  = 3'h3,
    IN2_LEVEL = 3'h4,
    IN2_PULSE = 3'h5
  } rci_in2_type;

  typedef enum logic [2:0] {
    OUT_ALARM = 3'h0,
    OUT_MOTOR = 3'h1,
    OUT_VEND  = 3'h2,
    OUT_MPUL  = 3'h3,
    OUT_VPUL  = 3'h4
  } rci_out_type;

  typedef enum logic [3:0] {
    ST_HALT  = 4'b0001,
    ST_PAUSE = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_PRIME = 4'b1000
  } rci_state_type;
endpackage

// ==== sim/rci_ext_ctrl.sv ====
// Far-side controller model: drives both remote inputs.
// Assumes the inputs idle high through a pull-up; low means active.
`timescale 1ns/1ns
module rci_ext_ctrl #(
  parameter int PULSE_CYC = 1100,
  parameter int LOCK_CYC  = 2100
) (
  input  wire logic clk_i,
  output logic      din1_o,
  output logic      din2_o
);
  initial begin
    din1_o = 1'b1;
    din2_o = 1'b1;
  end

  // Level change just after an edge
  task automatic drv(input int ch, input logic v);
    @(posedge clk_i);
    if (ch == 1) begin
      din1_o <= v;
    end else begin
      din2_o <= v;
    end
  endtask

  task automatic pulse(input int ch);
    drv(ch, 1'b0);
    repeat (PULSE_CYC) @(posedge clk_i);
    drv(ch, 1'b1);
  endtask

  task automatic rest();
    repeat (LOCK_CYC) @(posedge clk_i);
  endtask
endmodule // rci_ext_ctrl

// ==== sim/tb_rci_run_ctrl.sv ====
// Testbench of the remote run control: bus tasks and pin scenarios.
// Assumes a 10-cycle ms tick and short pulse dividers.
`timescale 1ns/1ns
module tb_rci_run_ctrl;
  import rci_pkg::*;
  localparam int MS = 10;
  localparam int MD = 2;
  localparam int VD = 4;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [3:0]  adr    = 4'h0;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        din1, din2, dout_o, oe_n, run, prime, eclr;
  logic        av     = 1'b1;
  logic        lstart = 1'b0;
  logic        lstop  = 1'b0;
  logic        perr   = 1'b0;
  logic        mt     = 1'b0;
  logic        vt     = 1'b0;
  logic [31:0] v;
  int          mismatches = 0;
  int          checked    = 0;
  int          nclr = 0;
  int          npul = 0;
  int          c0;

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (eclr === 1'b1) nclr++;
    if (oe_n === 1'b0) npul++;
  end

  rci_run_ctrl #(.MS_CYCLES(MS), .MOT_DIV(MD), .VOL_DIV(VD)) rci_run_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .din1_i(din1), .din2_i(din2), .analog_valid_i(av), .local_start_i(lstart),
    .local_stop_i(lstop), .pump_err_i(perr), .mot_tick_i(mt), .vol_tick_i(vt),
    .dout_i(oe_n ? 1'b1 : dout_o), .dout_o(dout_o), .dout_oe_n_o(oe_n), .run_o(run),
    .prime_o(prime), .err_clr_o(eclr));

  rci_ext_ctrl rci_ext_ctrl_inst (.clk_i(clk_i), .din1_o(din1), .din2_o(din2));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    v = rdat;
    chk(32'(ack), 32'h1, "ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic logic [31:0] cf(logic [1:0] i1, logic [2:0] i2, logic [2:0] o, logic t, logic an);
    return {18'h0, an, t, 1'b0, o, 1'b0, i2, 2'h0, i1};
  endfunction

  task automatic st(input logic [3:0] e);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(v[3:0]), 32'(e), "state");
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic tend(input string s);
    $display("%0t test %s done", $time, s);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    wt(16);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(v, 32'h0, "ctrl rst");
    bus(1'b0, ADDR_RUNTIME, 32'h0);
    chk(v, 32'(RUNTIME_RST), "runtime rst");
    st(ST_HALT);
    bus(1'b1, 4'hc, 32'hffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(v, 32'h0, "unmapped");
    tend("reset");
    bus(1'b1, ADDR_CTRL, cf(IN1_LEVEL, IN2_OFF, OUT_ALARM, 1'b0, 1'b0));
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(20);
    chk(32'(run), 32'h0, "halt start");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    @(posedge clk_i);
    lstart <= 1'b1;
    @(posedge clk_i);
    lstart <= 1'b0;
    wt(5);
    st(ST_PAUSE);
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(10);
    chk(32'(run), 32'h1, "level run");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    wt(10);
    chk(32'(run), 32'h0, "level stop");
    st(ST_PAUSE);
    chk(32'(v[STAT_LOCK_BIT]), 32'h1, "lock flag");
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(1000);
    chk(32'(run), 32'h0, "locked");
    wt(1100);
    chk(32'(run), 32'h1, "unlocked");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    rci_ext_ctrl_inst.rest();
    tend("level");
    bus(1'b1, ADDR_CTRL, cf(IN1_LEVEL, IN2_OFF, OUT_ALARM, 1'b0, 1'b1));
    @(posedge clk_i);
    av <= 1'b0;
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(20);
    chk(32'(run), 32'h0, "no analog");
    @(posedge clk_i);
    av <= 1'b1;
    wt(10);
    chk(32'(run), 32'h1, "analog ok");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    rci_ext_ctrl_inst.rest();
    tend("analog");
    bus(1'b1, ADDR_CTRL, cf(IN1_PULSE, IN2_OFF, OUT_ALARM, 1'b0, 1'b0));
    rci_ext_ctrl_inst.pulse(1);
    chk(32'(run), 32'h1, "pulse run");
    rci_ext_ctrl_inst.pulse(1);
    chk(32'(run), 32'h0, "pulse stop");
    rci_ext_ctrl_inst.rest();
    bus(1'b1, ADDR_RUNTIME, 32'h5);
    bus(1'b1, ADDR_CTRL, cf(IN1_PULSE, IN2_OFF, OUT_ALARM, 1'b1, 1'b0));
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(10);
    chk(32'(run), 32'h1, "timed run");
    wt(60);
    chk(32'(run), 32'h0, "timed stop");
    st(ST_PAUSE);
    chk(32'(v[STAT_VEND_BIT]), 32'h1, "vol end");
    bus(1'b1, ADDR_CTRL, cf(IN1_PULSE, IN2_OFF, OUT_VEND, 1'b1, 1'b0));
    wt(3);
    chk(32'(oe_n), 32'h0, "vol end out");
    wt(1100);
    rci_ext_ctrl_inst.drv(1, 1'b1);
    rci_ext_ctrl_inst.rest();
    tend("pulse");
    bus(1'b1, ADDR_CTRL, cf(IN1_LEVEL, IN2_OFF, OUT_ALARM, 1'b0, 1'b0));
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(10);
    chk(32'(run), 32'h1, "run");
    @(posedge clk_i);
    lstop <= 1'b1;
    @(posedge clk_i);
    lstop <= 1'b0;
    wt(5);
    st(ST_HALT);
    rci_ext_ctrl_inst.rest();
    chk(32'(run), 32'h0, "halt held");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    tend("halt");
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_RESET, OUT_ALARM, 1'b0, 1'b0));
    @(posedge clk_i);
    perr <= 1'b1;
    wt(5);
    chk(32'(oe_n), 32'h0, "alarm on");
    chk(32'(dout_o), 32'h0, "pin level");
    c0 = nclr;
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(10);
    st(ST_PAUSE);
    chk(32'(nclr - c0), 32'h1, "err clr");
    rci_ext_ctrl_inst.drv(2, 1'b1);
    @(posedge clk_i);
    perr <= 1'b0;
    wt(5);
    chk(32'(oe_n), 32'h1, "alarm off");
    tend("reset mode");
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_PRIME, OUT_ALARM, 1'b0, 1'b0));
    c0 = nclr;
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(10);
    chk(32'(nclr - c0), 32'h1, "prime clr");
    wt(500);
    chk(32'(prime), 32'h1, "priming");
    rci_ext_ctrl_inst.drv(2, 1'b1);
    wt(10);
    chk(32'(prime), 32'h0, "prime end");
    rci_ext_ctrl_inst.rest();
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_COMB, OUT_ALARM, 1'b0, 1'b0));
    c0 = nclr;
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(10);
    chk(32'(nclr - c0), 32'h1, "comb clr");
    wt(9500);
    chk(32'(prime), 32'h0, "comb wait");
    wt(1100);
    chk(32'(prime), 32'h1, "comb prime");
    rci_ext_ctrl_inst.drv(2, 1'b1);
    wt(10);
    chk(32'(prime), 32'h0, "comb end");
    rci_ext_ctrl_inst.rest();
    tend("prime");
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_LEVEL, OUT_MOTOR, 1'b0, 1'b0));
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(10);
    chk(32'(run), 32'h1, "foot run");
    chk(32'(oe_n), 32'h0, "motor out");
    rci_ext_ctrl_inst.drv(2, 1'b1);
    wt(10);
    chk(32'(run), 32'h0, "foot stop");
    rci_ext_ctrl_inst.rest();
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_PULSE, OUT_ALARM, 1'b0, 1'b0));
    rci_ext_ctrl_inst.pulse(2);
    chk(32'(run), 32'h1, "toggle on");
    rci_ext_ctrl_inst.pulse(2);
    chk(32'(run), 32'h0, "toggle off");
    rci_ext_ctrl_inst.rest();
    bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_LEVEL, OUT_ALARM, 1'b1, 1'b0));
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(10);
    rci_ext_ctrl_inst.drv(2, 1'b1);
    wt(10);
    chk(32'(run), 32'h1, "full cycle");
    wt(60);
    chk(32'(run), 32'h0, "cycle end");
    rci_ext_ctrl_inst.rest();
    tend("foot");
    bus(1'b1, ADDR_CTRL, cf(IN1_LEVEL, IN2_LEVEL, OUT_ALARM, 1'b0, 1'b0));
    rci_ext_ctrl_inst.drv(2, 1'b0);
    wt(20);
    chk(32'(run), 32'h0, "in2 locked out");
    bus(1'b1, ADDR_CTRL, 32'h0);
    rci_ext_ctrl_inst.drv(1, 1'b0);
    wt(20);
    chk(32'({run, prime}), 32'h0, "inputs off");
    rci_ext_ctrl_inst.drv(1, 1'b1);
    rci_ext_ctrl_inst.drv(2, 1'b1);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ADDR_CTRL, cf(IN1_OFF, IN2_OFF, (k == 1) ? OUT_VPUL : OUT_MPUL, 1'b0, 1'b0));
      wt(5);
      c0 = npul;
      repeat (8) begin
        @(posedge clk_i);
        mt <= 1'b1;
        vt <= 1'b1;
        @(posedge clk_i);
        mt <= 1'b0;
        vt <= 1'b0;
        wt(2);
      end
      wt(5);
      chk(32'(npul - c0), (k == 1) ? 32'(8 / VD) : 32'(8 / MD), "pulses");
    end
    tend("output pulses");
    test_done();
  end
endmodule // tb_rci_run_ctrl
